// >>> core/lcpc_top.sv
// Purpose: register bank for second line output and headphone charge pump
// Assumes: Avalon-MM slave with waitrequest, byte addresses, all inputs synchronous
// Notes:   every output is registered; one idle cycle separates bus answers
//
// The Avalon-MM register port was left to the implementer.
module lcpc_top (
  // clock and reset
  input  wire logic                CORE_CLOCK,
  input  wire logic                RST,
  // register bus
  input  wire logic [8:0]          AVS_ADDRESS,
  input  wire logic                AVS_READ,
  input  wire logic                AVS_WRITE,
  input  wire logic [31:0]         AVS_WRITEDATA,
  input  wire logic [3:0]          AVS_BYTEENABLE,
  output logic      [31:0]         AVS_READDATA,
  output logic                     AVS_WAITREQUEST,
  // headphone sequencer
  input  wire logic                SEQ_PUMP_START,
  input  wire logic                SEQ_PUMP_STOP,
  // pump level sources and pump clock divide setting
  input  wire logic [5:0]          LEFT_PHONE_GAIN,
  input  wire logic [5:0]          RIGHT_PHONE_GAIN,
  input  wire logic [5:0]          DAC_LEVEL,
  input  wire logic [7:0]          PUMP_DIV,
  // line output controls
  output lcpc_pkg::lcpc_line_s     LINE_B,
  // charge pump controls
  output logic                     PUMP_ON,
  output logic                     PUMP_CLK,
  output logic                     PUMP_HIGH_RAIL,
  output logic                     PUMP_LEVEL_TRACKING
);

  // register storage
  logic [15:0]          line_output_volume;
  logic [15:0]          line_mixer_two;
  logic [15:0]          charge_pump_control;
  logic [15:0]          supply_mode_control;
  lcpc_pkg::lcpc_bus_e  bus_state;
  logic [7:0]           div_count;      // core clock divider
  logic [15:0]          next_line_output_volume;
  logic [15:0]          next_line_mixer_two;
  logic [15:0]          next_charge_pump_control;
  logic [15:0]          next_supply_mode_control;
  lcpc_pkg::lcpc_bus_e  next_bus_state;
  logic [31:0]          next_readdata;
  logic                 next_waitrequest;
  logic [7:0]           next_div_count;
  logic                 next_pump_clk;
  logic                 next_high_rail;
  lcpc_pkg::lcpc_line_s next_line;
  logic [6:0]           idx;            // word index of the request
  logic                 wr_now;         // write takes effect this edge
  logic [15:0]          be_mask;        // byte lanes of the write
  logic [15:0]          wmerge;         // helper for lane merge
  logic [5:0]           gain_max;       // louder of the two headphones
  logic [5:0]           level;          // level steering the pump
  logic                 single;         // single-ended mode

  // address decode: the two low address bits are ignored, byte enables pick the lanes
  // lanes 2 and 3 carry nothing, the registers are 16 bits wide
  // a write is applied on the answer edge, never on the taking edge,
  // so the master may still change its data up to the edge it sees the answer
  assign idx     = AVS_ADDRESS[8:2];
  assign wr_now  = (bus_state == lcpc_pkg::BUS_ACK) && AVS_WRITE;
  assign be_mask = {{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

  // merge written lanes into an old value
  function automatic logic [15:0] merge(input logic [15:0] old_v, input logic [15:0] new_v,
                                        input logic [15:0] mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction

  // bus handshake and register writes
  always_comb begin
    wmerge                   = 16'h0000;
    next_bus_state           = bus_state;
    next_waitrequest         = 1'b1;
    next_readdata            = AVS_READDATA;
    next_line_output_volume  = line_output_volume;
    next_line_mixer_two      = line_mixer_two;
    next_charge_pump_control = charge_pump_control;
    next_supply_mode_control = supply_mode_control;
    unique case (bus_state)
      lcpc_pkg::BUS_IDLE: begin
        // request seen: answer in the next cycle
        if (AVS_READ || AVS_WRITE) begin
          next_bus_state   = lcpc_pkg::BUS_ACK;
          next_waitrequest = 1'b0;
          next_readdata    = 32'h0000_0000;
          if (AVS_READ) begin
            unique case (idx)
              lcpc_pkg::IDX_LINE_OUTPUT_VOLUME:  next_readdata = {16'h0000, line_output_volume};
              lcpc_pkg::IDX_LINE_MIXER_TWO:      next_readdata = {16'h0000, line_mixer_two};
              lcpc_pkg::IDX_CHARGE_PUMP_CONTROL: next_readdata = {16'h0000, charge_pump_control};
              lcpc_pkg::IDX_SUPPLY_MODE_CONTROL: next_readdata = {16'h0000, supply_mode_control};
              default:                           next_readdata = 32'h0000_0000; // unmapped reads zero
            endcase
          end
        end
      end
      lcpc_pkg::BUS_ACK: begin
        // answer edge: write lands, then rest one cycle
        next_bus_state = lcpc_pkg::BUS_IDLE;
        if (wr_now) begin
          wmerge = AVS_WRITEDATA[15:0];
          unique case (idx)
            lcpc_pkg::IDX_LINE_OUTPUT_VOLUME: begin
              // only the three second-pair bits are kept
              next_line_output_volume = merge(line_output_volume, wmerge, be_mask) & 16'h0007; // R1 R2 R3
            end
            lcpc_pkg::IDX_LINE_MIXER_TWO: begin
              // all path bits stored regardless of mode
              next_line_mixer_two = merge(line_mixer_two, wmerge, be_mask) & 16'h0077; // R18
            end
            lcpc_pkg::IDX_CHARGE_PUMP_CONTROL: begin
              next_charge_pump_control = merge(charge_pump_control, wmerge, be_mask); // R9
            end
            lcpc_pkg::IDX_SUPPLY_MODE_CONTROL: begin
              next_supply_mode_control = merge(supply_mode_control, wmerge, be_mask) & 16'h0001; // R11
            end
            default: begin
              // unmapped writes are dropped
              wmerge = 16'h0000;
            end
          endcase
        end
      end
    endcase
    // sequencer drives the enable; start wins over any clear
    if (SEQ_PUMP_STOP) begin
      next_charge_pump_control[lcpc_pkg::BIT_PUMP_ON] = 1'b0; // R16
    end
    if (SEQ_PUMP_START) begin
      next_charge_pump_control[lcpc_pkg::BIT_PUMP_ON] = 1'b1; // R16
    end
  end

  // register bank flops
  always_ff @(posedge CORE_CLOCK) begin
    if (RST) begin
      bus_state           <= lcpc_pkg::BUS_IDLE;
      AVS_WAITREQUEST     <= 1'b1;
      AVS_READDATA        <= 32'h0000_0000;
      line_output_volume  <= lcpc_pkg::RST_LINE_OUTPUT_VOLUME;  // R1 R2 R3
      line_mixer_two      <= lcpc_pkg::RST_LINE_MIXER_TWO;
      charge_pump_control <= lcpc_pkg::RST_CHARGE_PUMP_CONTROL; // R9
      supply_mode_control <= lcpc_pkg::RST_SUPPLY_MODE_CONTROL; // R11
    end else begin
      bus_state           <= next_bus_state;
      AVS_WAITREQUEST     <= next_waitrequest;
      AVS_READDATA        <= next_readdata;
      line_output_volume  <= next_line_output_volume;
      line_mixer_two      <= next_line_mixer_two;
      charge_pump_control <= next_charge_pump_control;
      supply_mode_control <= next_supply_mode_control;
    end
  end

  // line output path gating by mode
  // path bits of the other topology stay stored but are forced off here,
  // so the analogue side never sees a path that its mode cannot carry
  assign single = line_mixer_two[lcpc_pkg::BIT_TOPOLOGY]; // R8
  always_comb begin
    next_line.line_b_neg_silence      = line_output_volume[lcpc_pkg::BIT_NEG_SILENCE]; // R1
    next_line.line_b_pos_silence      = line_output_volume[lcpc_pkg::BIT_POS_SILENCE]; // R2
    next_line.line_b_attenuate        = line_output_volume[lcpc_pkg::BIT_ATTENUATE];   // R3
    next_line.line_b_topology_sel     = single;                                        // R8
    next_line.right_mix_to_line_b_neg = line_mixer_two[lcpc_pkg::BIT_RMIX_NEG] & single;  // R4 R18
    next_line.left_mix_to_line_b_neg  = line_mixer_two[lcpc_pkg::BIT_LMIX_NEG] & single;  // R5 R18
    next_line.left_amp_to_line_b      = line_mixer_two[lcpc_pkg::BIT_LAMP] & ~single;     // R6 R18
    next_line.right_amp_to_line_b     = line_mixer_two[lcpc_pkg::BIT_RAMP] & ~single;     // R7 R18
    // one bit, meaning follows the mode
    next_line.right_mix_to_line_b_pos = line_mixer_two[lcpc_pkg::BIT_RMIX_POS];           // R8
  end

  // pump mode source and clock divider
  // the rail choice is a simple threshold on the steering level;
  // the divider restarts from zero whenever the pump is switched off,
  // so the first half period after enable is always a full one
  assign gain_max = (LEFT_PHONE_GAIN > RIGHT_PHONE_GAIN) ? LEFT_PHONE_GAIN : RIGHT_PHONE_GAIN; // R12
  assign level    = supply_mode_control[lcpc_pkg::BIT_LEVEL_TRACK] ? DAC_LEVEL : gain_max;   // R11 R13
  always_comb begin
    next_high_rail = charge_pump_control[lcpc_pkg::BIT_PUMP_ON] && (level >= lcpc_pkg::PUMP_HIGH_LEVEL);
    next_div_count = div_count;
    next_pump_clk  = PUMP_CLK;
    if (!charge_pump_control[lcpc_pkg::BIT_PUMP_ON]) begin
      // pump off: clock parked low
      next_div_count = 8'h00;
      next_pump_clk  = 1'b0;
    end else if (div_count >= PUMP_DIV) begin
      // half period reached: toggle
      next_div_count = 8'h00;        // R15
      next_pump_clk  = ~PUMP_CLK;    // R15
    end else begin
      next_div_count = div_count + 8'h01;
    end
  end

  // output flops
  always_ff @(posedge CORE_CLOCK) begin
    if (RST) begin
      LINE_B              <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
      PUMP_ON             <= 1'b0;
      PUMP_CLK            <= 1'b0;
      PUMP_HIGH_RAIL      <= 1'b0;
      PUMP_LEVEL_TRACKING <= 1'b0;
      div_count           <= 8'h00;
    end else begin
      LINE_B              <= next_line;
      PUMP_ON             <= charge_pump_control[lcpc_pkg::BIT_PUMP_ON]; // R9
      PUMP_CLK            <= next_pump_clk;
      PUMP_HIGH_RAIL      <= next_high_rail;                             // R12 R13
      PUMP_LEVEL_TRACKING <= supply_mode_control[lcpc_pkg::BIT_LEVEL_TRACK];
      div_count           <= next_div_count;
    end
  end

  // checks
  default clocking cb @(posedge CORE_CLOCK); endclocking
  default disable iff (RST);

  sequence s_vol_write;
    wr_now && idx == lcpc_pkg::IDX_LINE_OUTPUT_VOLUME && AVS_BYTEENABLE[0];
  endsequence

  AST_NEG_MUTE: assert property (s_vol_write |-> ##2 LINE_B.line_b_neg_silence == $past(AVS_WRITEDATA[2], 2)) // R1
    else $error("negative pin mute does not follow write");
  AST_POS_MUTE: assert property (s_vol_write |-> ##2 LINE_B.line_b_pos_silence == $past(AVS_WRITEDATA[1], 2)) // R2
    else $error("positive pin mute does not follow write");
  AST_ATTEN: assert property (s_vol_write |-> ##2 LINE_B.line_b_attenuate == $past(AVS_WRITEDATA[0], 2)) // R3
    else $error("attenuation does not follow write");
  AST_RMIX_NEG: assert property (LINE_B.right_mix_to_line_b_neg |-> LINE_B.line_b_topology_sel) // R4
    else $error("right mix to negative pin outside single-ended mode");
  AST_LMIX_NEG: assert property (LINE_B.left_mix_to_line_b_neg |-> LINE_B.line_b_topology_sel) // R5
    else $error("left mix to negative pin outside single-ended mode");
  AST_AMPS: assert property ((LINE_B.left_amp_to_line_b || LINE_B.right_amp_to_line_b)
                             |-> !LINE_B.line_b_topology_sel) // R6
    else $error("amp path active in single-ended mode");
  AST_RAMP: assert property ($rose(LINE_B.right_amp_to_line_b) |-> $past(line_mixer_two[1])) // R7
    else $error("right amp path without its bit");
  AST_SEQ_START: assert property (SEQ_PUMP_START |-> ##2 PUMP_ON) // R16
    else $error("start sequence did not enable pump");
  AST_SEQ_STOP: assert property (SEQ_PUMP_STOP && !SEQ_PUMP_START && !wr_now |-> ##2 !PUMP_ON) // R16
    else $error("shut-down sequence did not disable pump");
  AST_TRACK: assert property (supply_mode_control[0] && charge_pump_control[15] && DAC_LEVEL >= 6'h30
                              |=> PUMP_HIGH_RAIL) // R13
    else $error("level tracking ignored dac level");
  AST_GAIN: assert property (!supply_mode_control[0] && charge_pump_control[15]
                             && LEFT_PHONE_GAIN < 6'h30 && RIGHT_PHONE_GAIN < 6'h30 |=> !PUMP_HIGH_RAIL) // R12
    else $error("volume control ignored gain settings");
  AST_ANSWER: assert property ((AVS_READ || AVS_WRITE) && bus_state == lcpc_pkg::BUS_IDLE
                               |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
    else $error("bus answer not one cycle");

  // mixer register writes and their effect on the pins
  sequence s_mix_write;
    wr_now && idx == lcpc_pkg::IDX_LINE_MIXER_TWO && AVS_BYTEENABLE[0];
  endsequence

  AST_TOPOLOGY: assert property (s_mix_write |-> ##2
                                 LINE_B.line_b_topology_sel == $past(AVS_WRITEDATA[lcpc_pkg::BIT_TOPOLOGY], 2)) // R8
    else $error("topology select does not follow write");
  AST_RMIX_POS: assert property (s_mix_write |-> ##2
                                 LINE_B.right_mix_to_line_b_pos == $past(AVS_WRITEDATA[lcpc_pkg::BIT_RMIX_POS], 2)) // R8
    else $error("right mix path bit does not follow write");
  AST_MIX_STORED: assert property (s_mix_write |=> line_mixer_two == ($past(AVS_WRITEDATA[15:0]) & 16'h0077)) // R18
    else $error("mixer path bits not stored");
  AST_LAMP: assert property ($rose(LINE_B.left_amp_to_line_b) |-> $past(line_mixer_two[lcpc_pkg::BIT_LAMP])) // R6
    else $error("left amp path without its bit");

  // read answers carry the register seen on the taking edge
  sequence s_bus_read;
    bus_state == lcpc_pkg::BUS_IDLE && AVS_READ;
  endsequence

  AST_READ_VOL: assert property (s_bus_read ##0 (idx == lcpc_pkg::IDX_LINE_OUTPUT_VOLUME)
                                 |=> AVS_READDATA == {16'h0000, $past(line_output_volume)}) // R1
    else $error("volume read answer wrong");
  AST_READ_PUMP: assert property (s_bus_read ##0 (idx == lcpc_pkg::IDX_CHARGE_PUMP_CONTROL)
                                  |=> AVS_READDATA == {16'h0000, $past(charge_pump_control)}) // R9
    else $error("pump read answer wrong");

  // software control of the pump enable and the tracking select
  sequence s_pump_write;
    wr_now && idx == lcpc_pkg::IDX_CHARGE_PUMP_CONTROL && AVS_BYTEENABLE[1] && !SEQ_PUMP_START && !SEQ_PUMP_STOP;
  endsequence

  sequence s_supply_write;
    wr_now && idx == lcpc_pkg::IDX_SUPPLY_MODE_CONTROL && AVS_BYTEENABLE[0];
  endsequence

  AST_PUMP_WRITE: assert property (s_pump_write |=>
                                   charge_pump_control[lcpc_pkg::BIT_PUMP_ON] == $past(AVS_WRITEDATA[15])) // R9
    else $error("pump enable does not follow write");
  AST_TRACK_SEL: assert property (s_supply_write |-> ##2 PUMP_LEVEL_TRACKING == $past(AVS_WRITEDATA[0], 2)) // R11
    else $error("tracking select does not follow write");

  // pump clock while off and while running, rail while off
  AST_CLK_PARK: assert property (!charge_pump_control[lcpc_pkg::BIT_PUMP_ON] |=> !PUMP_CLK) // R15
    else $error("pump clock runs while pump off");
  AST_CLK_TOGGLE: assert property (charge_pump_control[lcpc_pkg::BIT_PUMP_ON] && div_count >= PUMP_DIV
                                   |=> PUMP_CLK != $past(PUMP_CLK)) // R15
    else $error("pump clock missed its half period");
  AST_RAIL_OFF: assert property (!charge_pump_control[lcpc_pkg::BIT_PUMP_ON] |=> !PUMP_HIGH_RAIL) // R12
    else $error("high rail while pump off");

endmodule

// >>> core/lcpc_pkg.sv
// Purpose: constants and types for the second line output and charge pump control bank
// Assumes: 16-bit registers, one per aligned 32-bit word, byte address = index * 4
// Notes:   all offsets, fields, reset values and counts live here
//
// Behaviour
// (R1) volume bit 2 mutes negative pin, resets muted
// (R2) volume bit 1 mutes positive pin, resets muted
// (R3) volume bit 0 gives joint -6dB, resets clear
// (R4) mixer bit 6 right mix to negative, single-ended
// (R5) mixer bit 5 left mix to negative, single-ended
// (R6) mixer bit 2 left amp, differential only
// (R7) mixer bit 1 right amp, differential only
// (R8) bit 4 picks mode; bit 0 right mix path
// (R9) pump bit 15 enables charge pump, resets 0
// (R10) software keeps pump bits 14:0 at default
// (R11) supply bit 0 picks volume or level control
// (R12) volume control: mode from headphone gain settings
// (R13) level control: mode from measured DAC level
// (R14) level control only when DAC sole source
// (R15) pump clock divided from core clock automatically
// (R16) start sequence sets enable, shut-down clears it
// (R17) unused headphones: software keeps pump and drivers off
// (R18) mismatched-mode path bits stored but without effect
package lcpc_pkg;

  // register indices, byte address is four times these
  localparam logic [6:0] IDX_LINE_OUTPUT_VOLUME  = 7'h1e;
  localparam logic [6:0] IDX_LINE_MIXER_TWO      = 7'h35;
  localparam logic [6:0] IDX_CHARGE_PUMP_CONTROL = 7'h4c;
  localparam logic [6:0] IDX_SUPPLY_MODE_CONTROL = 7'h51;

  // field positions
  localparam int BIT_NEG_SILENCE   = 2;
  localparam int BIT_POS_SILENCE   = 1;
  localparam int BIT_ATTENUATE     = 0;
  localparam int BIT_RMIX_NEG      = 6;
  localparam int BIT_LMIX_NEG      = 5;
  localparam int BIT_TOPOLOGY      = 4;
  localparam int BIT_LAMP          = 2;
  localparam int BIT_RAMP          = 1;
  localparam int BIT_RMIX_POS      = 0;
  localparam int BIT_PUMP_ON       = 15;
  localparam int BIT_LEVEL_TRACK   = 0;

  // reset values
  localparam logic [15:0] RST_LINE_OUTPUT_VOLUME  = 16'h0006;
  localparam logic [15:0] RST_LINE_MIXER_TWO      = 16'h0000;
  localparam logic [15:0] RST_CHARGE_PUMP_CONTROL = 16'h1f25;
  localparam logic [15:0] RST_SUPPLY_MODE_CONTROL = 16'h0000;

  // level at or above which the pump runs on its wide rails
  localparam logic [5:0] PUMP_HIGH_LEVEL = 6'h30;

  // bus answer states
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } lcpc_bus_e;

  // second line output controls as seen by the analogue drivers
  typedef struct packed {
    logic line_b_neg_silence;
    logic line_b_pos_silence;
    logic line_b_attenuate;
    logic line_b_topology_sel;
    logic right_mix_to_line_b_neg;
    logic left_mix_to_line_b_neg;
    logic left_amp_to_line_b;
    logic right_amp_to_line_b;
    logic right_mix_to_line_b_pos;
  } lcpc_line_s;

endpackage

// >>> tb/lineout2_chargepump_ctrl_tb.sv
// Purpose: self-checking bench for the line output b and charge pump register bank
// Assumes: one idle cycle between bus answers, outputs settle one edge after a write lands
// Notes:   each scenario is a task; inputs change by non-blocking assignment at rising edges
module lineout2_chargepump_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;

  // clock, reset and bus stimulus
  logic                 CORE_CLOCK = 1'b0;
  logic                 RST = 1'b1;
  logic [8:0]           AVS_ADDRESS = 9'h000;
  logic                 AVS_READ = 1'b0;
  logic                 AVS_WRITE = 1'b0;
  logic [31:0]          AVS_WRITEDATA = 32'h0;
  logic [3:0]           AVS_BYTEENABLE = 4'hf;
  logic [31:0]          AVS_READDATA;
  logic                 AVS_WAITREQUEST;
  // sequencer, level sources and pump clock divide setting
  logic                 SEQ_PUMP_START = 1'b0;
  logic                 SEQ_PUMP_STOP = 1'b0;
  logic [5:0]           LEFT_PHONE_GAIN = 6'h00;
  logic [5:0]           RIGHT_PHONE_GAIN = 6'h00;
  logic [5:0]           DAC_LEVEL = 6'h00;
  logic [7:0]           PUMP_DIV = 8'h01;
  // observed controls
  lcpc_pkg::lcpc_line_s LINE_B;
  logic                 PUMP_ON;
  logic                 PUMP_CLK;
  logic                 PUMP_HIGH_RAIL;
  logic                 PUMP_LEVEL_TRACKING;
  // result counters
  int                   n_errors = 0;
  int                   checks_done = 0;
  logic [31:0]          rd;

  lcpc_top i_dut (.CORE_CLOCK(CORE_CLOCK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .SEQ_PUMP_START(SEQ_PUMP_START),
    .SEQ_PUMP_STOP(SEQ_PUMP_STOP), .LEFT_PHONE_GAIN(LEFT_PHONE_GAIN), .RIGHT_PHONE_GAIN(RIGHT_PHONE_GAIN),
    .DAC_LEVEL(DAC_LEVEL), .PUMP_DIV(PUMP_DIV), .LINE_B(LINE_B), .PUMP_ON(PUMP_ON), .PUMP_CLK(PUMP_CLK),
    .PUMP_HIGH_RAIL(PUMP_HIGH_RAIL), .PUMP_LEVEL_TRACKING(PUMP_LEVEL_TRACKING));

  // free-running core clock, 100 ns period
  initial begin
    forever #50 CORE_CLOCK = ~CORE_CLOCK;
  end

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // one bus cycle held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [8:0] a, input logic [15:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    int n;
    @(posedge CORE_CLOCK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= {16'h0, d};
    AVS_BYTEENABLE <= be;
    AVS_WRITE <= wr;
    AVS_READ <= ~wr;
    for (n = 0; n < 50; n++) begin
      @(posedge CORE_CLOCK);
      if (AVS_WAITREQUEST === 1'b0) break;
    end
    q = AVS_READDATA;
    if (n == 50) check(32'h1, 32'h0, "no bus answer");
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
  endtask

  // write then let the outputs settle
  task automatic wr_settle(input logic [8:0] a, input logic [15:0] d, input logic [3:0] be);
    logic [31:0] dummy;
    bus(1'b1, a, d, be, dummy);
    repeat (2) @(posedge CORE_CLOCK);
    #1;
  endtask

  // read and compare
  task automatic rd_check(input logic [8:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 16'h0, 4'hf, rd);
    check(rd, exp, what);
  endtask

  // reset values of registers and controls
  task automatic t_reset;
    check({23'h0, LINE_B}, {23'h0, 9'h180}, "line reset");
    check({29'h0, PUMP_ON, PUMP_CLK, PUMP_LEVEL_TRACKING}, 32'h0, "pump reset");
    rd_check(9'h078, 32'h0006, "volume reset");
    rd_check(9'h0d4, 32'h0000, "mixer reset");
    rd_check(9'h130, 32'h1f25, "pump reg reset");
    rd_check(9'h144, 32'h0000, "supply reset");
  endtask

  // mute, attenuate and lane handling on the volume register
  task automatic t_volume;
    wr_settle(9'h078, 16'hfffb, 4'h3);
    check({23'h0, LINE_B}, {23'h0, 9'h0c0}, "neg unmuted, -6dB");
    rd_check(9'h078, 32'h0003, "volume readback");
    wr_settle(9'h078, 16'h0000, 4'h2);
    rd_check(9'h078, 32'h0003, "upper lane only");
    wr_settle(9'h078, 16'h0001, 4'h1);
    check({23'h0, LINE_B}, {23'h0, 9'h040}, "unmuted, -6dB");
  endtask

  // paths gated by topology while still stored
  task automatic t_mixer;
    wr_settle(9'h0d4, 16'h0067, 4'h3);
    check({23'h0, LINE_B}, {23'h0, 9'h047}, "differential paths");
    rd_check(9'h0d4, 32'h0067, "mixer stored");
    wr_settle(9'h0d4, 16'hff77, 4'h3);
    check({23'h0, LINE_B}, {23'h0, 9'h079}, "single-ended paths");
    rd_check(9'h0d4, 32'h0077, "mixer reserved zero");
    wr_settle(9'h0d4, 16'h0010, 4'h1);
    check({23'h0, LINE_B}, {23'h0, 9'h060}, "all paths off");
  endtask

  // enable bit, divided clock and sequencer control
  task automatic t_pump;
    int tg;
    logic last;
    wr_settle(9'h130, 16'h9f00, 4'h2);
    check({31'h0, PUMP_ON}, 32'h1, "pump on");
    rd_check(9'h130, 32'h9f25, "pump low bits kept");
    repeat (10) @(posedge CORE_CLOCK);
    #1;
    tg = 0;
    last = PUMP_CLK;
    repeat (40) begin
      @(posedge CORE_CLOCK);
      #1;
      if (PUMP_CLK !== last) tg++;
      last = PUMP_CLK;
    end
    check(tg, 32'h14, "pump clock toggles");
    @(posedge CORE_CLOCK);
    SEQ_PUMP_STOP <= 1'b1;
    @(posedge CORE_CLOCK);
    SEQ_PUMP_STOP <= 1'b0;
    repeat (4) @(posedge CORE_CLOCK);
    #1;
    check({30'h0, PUMP_ON, PUMP_CLK}, 32'h0, "sequencer stop");
    rd_check(9'h130, 32'h1f25, "stop readback");
    @(posedge CORE_CLOCK);
    SEQ_PUMP_START <= 1'b1;
    SEQ_PUMP_STOP <= 1'b1;
    @(posedge CORE_CLOCK);
    SEQ_PUMP_START <= 1'b0;
    SEQ_PUMP_STOP <= 1'b0;
    repeat (4) @(posedge CORE_CLOCK);
    #1;
    check({31'h0, PUMP_ON}, 32'h1, "start wins");
    rd_check(9'h130, 32'h9f25, "start readback");
  endtask

  // rail selection from gains or measured level
  task automatic t_level;
    logic [2:0] k;
    logic [5:0] gl [6] = '{6'h2f, 6'h10, 6'h00, 6'h3f, 6'h00, 6'h30};
    logic [5:0] dl [6] = '{6'h3f, 6'h30, 6'h3f, 6'h00, 6'h2f, 6'h10};
    logic       md [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    logic       ex [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    for (k = 0; k < 6; k++) begin
      if (k == 4) begin
        wr_settle(9'h144, 16'hffff, 4'h3);
        check({31'h0, PUMP_LEVEL_TRACKING}, 32'h1, "level tracking");
        rd_check(9'h144, 32'h0001, "supply readback");
      end
      @(posedge CORE_CLOCK);
      LEFT_PHONE_GAIN <= gl[k];
      RIGHT_PHONE_GAIN <= (k == 1) ? 6'h30 : 6'h05;
      DAC_LEVEL <= dl[k];
      repeat (3) @(posedge CORE_CLOCK);
      #1;
      check({31'h0, PUMP_HIGH_RAIL}, {31'h0, ex[k] | (md[k] & (dl[k] >= 6'h30))}, "high rail");
    end
    @(posedge CORE_CLOCK);
    DAC_LEVEL <= 6'h30;
    repeat (3) @(posedge CORE_CLOCK);
    #1;
    check({31'h0, PUMP_HIGH_RAIL}, 32'h1, "level drives rail");
    wr_settle(9'h130, 16'h1f25, 4'h3);
    check({31'h0, PUMP_ON, PUMP_HIGH_RAIL}, 32'h0, "pump off, no rail");
  endtask

  // unmapped places answer with zero and drop writes
  task automatic t_unmapped;
    wr_settle(9'h07c, 16'hffff, 4'h3);
    rd_check(9'h07c, 32'h0, "unmapped read");
    rd_check(9'h000, 32'h0, "unmapped low");
    rd_check(9'h078, 32'h0001, "neighbour untouched");
  endtask

  // verdict
  task automatic tally_and_finish;
    $display("checks_done %0d n_errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // watchdog well past the expected run
  initial begin
    #2000000;
    n_errors++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    repeat (20) @(posedge CORE_CLOCK);
    RST <= 1'b0;
    @(posedge CORE_CLOCK);
    #1;
    t_reset();
    t_volume();
    t_mixer();
    t_pump();
    t_level();
    t_unmapped();
    tally_and_finish();
  end
endmodule
